// [tmrb_cfg.svh]
// register offsets, field positions and reset values of the timer register block
// assumes byte-wide register bus, offsets are byte addresses
`ifndef TMRB_CFG_SVH
`define TMRB_CFG_SVH
`define TMRB_ADDR_W 4
`define TMRB_OFS_CTRL 4'h1
`define TMRB_OFS_EVCTRL 4'h4
`define TMRB_OFS_INTERRUPT_CONTROL 4'h5
`define TMRB_OFS_INTERRUPT_FLAGS 4'h6
`define TMRB_OFS_RUNSTATE 4'h7
`define TMRB_OFS_DEBUG_CONTROL 4'h8
`define TMRB_OFS_STAGING 4'h9
`define TMRB_OFS_COUNTER_LOW_BYTE 4'ha
`define TMRB_OFS_COUNTER_HIGH_BYTE 4'hb
`define TMRB_OFS_CMPL 4'hc
`define TMRB_OFS_CMPH 4'hd
`define TMRB_BIT_CAPTURE_FLAG 0
`define TMRB_BIT_RUN 0
`define TMRB_BIT_DBGCONT 0
`define TMRB_BIT_EDGE 4
`define TMRB_BIT_CAPTEI 0
`define TMRB_BIT_ENABLE 0
`define TMRB_RST_BYTE 8'h00
`define TMRB_RST_WORD 16'h0000
`endif

// [tmrb_pkg.sv]
// types shared by the timer register block
// assumes tmrb_cfg.svh is compiled alongside
package tmrb_pkg;
    typedef enum logic [2:0] {
        TMRB_PERIODIC = 3'h0,
        TMRB_TIMEOUT = 3'h1,
        TMRB_CAPEVT = 3'h2,
        TMRB_FREQ = 3'h3,
        TMRB_PW = 3'h4,
        TMRB_FRQPW = 3'h5,
        TMRB_SINGLE = 3'h6,
        TMRB_PWM8 = 3'h7
    } tmrb_mode_t;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [3:0] addr;
        logic [7:0] wdata;
    } tmrb_bus_t;

    typedef struct packed {
        logic run;
        logic clearCount;
        logic capture;
        logic setFlag;
    } tmrb_evact_t;
endpackage

// [tmrb_edge.sv]
// event edge detector: one-cycle pulses on rising and falling input
// assumes the event input is synchronous to mclk
`timescale 1ns/100ps
module tmrb_edge (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic evIn,
    output logic rise,
    output logic fall
);
    logic prev_q;
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else if (enable) begin
            prev_q <= evIn;
        end
    end
    assign rise = enable & evIn & ~prev_q;
    assign fall = enable & ~evIn & prev_q;
endmodule

// [tmrb_mode.sv]
// per-mode event decoding: maps active and opposite edges to counter actions
// assumes edges already qualified by capture enable and debug halt
`timescale 1ns/100ps
module tmrb_mode (
    input tmrb_pkg::tmrb_mode_t mode,
    input wire logic actEdge,
    input wire logic othEdge,
    input wire logic running,
    input wire logic secondPhase,
    output tmrb_pkg::tmrb_evact_t act
);
    always_comb begin
        act = '0;
        act.run = running;
        case (mode)
            tmrb_pkg::TMRB_TIMEOUT: begin
                if (actEdge) begin
                    act.run = 1'b1;
                end else if (othEdge) begin
                    act.run = 1'b0;
                end
            end
            tmrb_pkg::TMRB_CAPEVT: begin
                act.capture = actEdge;
                act.setFlag = actEdge;
            end
            tmrb_pkg::TMRB_FREQ: begin
                act.capture = actEdge;
                act.clearCount = actEdge;
                act.setFlag = actEdge;
            end
            tmrb_pkg::TMRB_PW: begin
                act.clearCount = actEdge;
                act.capture = othEdge;
                act.setFlag = othEdge;
            end
            tmrb_pkg::TMRB_FRQPW: begin
                // first edge restarts, second active edge stops the count
                if (actEdge && !secondPhase) begin
                    act.clearCount = 1'b1;
                    act.run = 1'b1;
                end else if (actEdge) begin
                    act.run = 1'b0;
                    act.setFlag = 1'b1;
                end
                act.capture = othEdge & secondPhase;
            end
            tmrb_pkg::TMRB_SINGLE: begin
                if (actEdge && !running) begin
                    act.run = 1'b1;
                    act.clearCount = 1'b1;
                end
            end
            default: begin
                act = act;
            end
        endcase
    end
endmodule

// [tmrb_regs.sv]
// timer register block: flag, run state, debug control, staging byte,
// counter and capture/compare with per-mode behaviour
// assumes a byte-wide register port synchronous to mclk, one access per cycle
`timescale 1ns/100ps
`include "tmrb_cfg.svh"

module tmrb_regs #(
    parameter int CNT_W = 16
) (
    input wire logic mclk,
    input wire logic rst_n,
    input tmrb_pkg::tmrb_bus_t bus,
    output logic [7:0] rdata,
    input wire logic debugBreak,
    input wire logic evIn,
    output logic irq
);
    initial begin
        if (CNT_W != 16) begin
            $error("tmrb_regs supports only a 16-bit counter");
        end
    end

    // ==========================================================
    // state
    typedef struct packed {
        logic enable;
        tmrb_pkg::tmrb_mode_t mode;
        logic edgeSel;
        logic captEn;
        logic intEn;
        logic flag;
        logic running;
        logic secondPhase;
        logic dbgCont;
        logic [7:0] staging;
        logic [15:0] count;
        logic [15:0] capture_compare_value;
        logic [7:0] rdata;
    } tmrb_state_t;

    tmrb_state_t s_q, s_d;

    logic active;
    logic rise, fall, actEdge, othEdge;
    tmrb_pkg::tmrb_evact_t act;
    logic topHit;
    logic wr, rd;
    logic [3:0] a;

    assign wr = bus.wrEn;
    assign rd = bus.rdEn;
    assign a = bus.addr;
    // halted in break unless continue is set; events ignored too
    assign active = s_q.enable & (~debugBreak | s_q.dbgCont);

    tmrb_edge u_edge (
        .mclk(mclk),
        .rst_n(rst_n),
        .enable(active & s_q.captEn),
        .evIn(evIn),
        .rise(rise),
        .fall(fall)
    );

    assign actEdge = s_q.edgeSel ? fall : rise;
    assign othEdge = s_q.edgeSel ? rise : fall;

    tmrb_mode u_mode (
        .mode(s_q.mode),
        .actEdge(actEdge),
        .othEdge(othEdge),
        .running(s_q.running),
        .secondPhase(s_q.secondPhase),
        .act(act)
    );

    // ==========================================================
    // TOP / compare match
    always_comb begin
        topHit = 1'b0;
        case (s_q.mode)
            tmrb_pkg::TMRB_PERIODIC, tmrb_pkg::TMRB_TIMEOUT, tmrb_pkg::TMRB_SINGLE: begin
                topHit = active & s_q.running & (s_q.count == s_q.capture_compare_value);
            end
            tmrb_pkg::TMRB_PWM8: begin
                // low byte is the period, high byte the compare point
                topHit = active & s_q.running & (s_q.count[7:0] == s_q.capture_compare_value[15:8]);
            end
            default: begin
                topHit = 1'b0;
            end
        endcase
    end

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.rdata = `TMRB_RST_BYTE;

        // counter and run state
        if (active) begin
            s_d.running = act.run;
            if (s_q.mode == tmrb_pkg::TMRB_PERIODIC || s_q.mode == tmrb_pkg::TMRB_PWM8) begin
                s_d.running = 1'b1;
            end
            if (s_q.mode == tmrb_pkg::TMRB_FRQPW && actEdge) begin
                s_d.secondPhase = ~s_q.secondPhase;
            end
            if (act.capture) begin
                s_d.capture_compare_value = s_q.count;
            end
            if (act.clearCount) begin
                s_d.count = `TMRB_RST_WORD;
            end else if (topHit) begin
                if (s_q.mode == tmrb_pkg::TMRB_PWM8) begin
                    // flag point only; the period wrap stays on the low byte
                    s_d.count = (s_q.count[7:0] == s_q.capture_compare_value[7:0]) ? 16'h0000 : s_q.count + 16'h0001;
                end else begin
                    s_d.count = `TMRB_RST_WORD;
                end
                if (s_q.mode == tmrb_pkg::TMRB_SINGLE || s_q.mode == tmrb_pkg::TMRB_TIMEOUT) begin
                    s_d.running = 1'b0;
                end
            end else if (s_q.mode == tmrb_pkg::TMRB_PWM8 && s_q.running
                         && s_q.count[7:0] == s_q.capture_compare_value[7:0]) begin
                s_d.count = 16'h0000;
            end else if (s_q.running) begin
                s_d.count = s_q.count + 16'h0001;
            end
        end
        if (!s_q.enable) begin
            s_d.running = 1'b0;
            s_d.secondPhase = 1'b0;
        end

        // flag: software clear first so a same-cycle set wins
        if (wr && a == `TMRB_OFS_INTERRUPT_FLAGS && bus.wdata[`TMRB_BIT_CAPTURE_FLAG]) begin
            s_d.flag = 1'b0;
        end
        if (rd && a == `TMRB_OFS_CMPL && s_q.mode inside {tmrb_pkg::TMRB_CAPEVT, tmrb_pkg::TMRB_FREQ,
                                                         tmrb_pkg::TMRB_PW, tmrb_pkg::TMRB_FRQPW}) begin
            s_d.flag = 1'b0;
        end
        if (act.setFlag || topHit) begin
            s_d.flag = 1'b1;
        end

        // register writes; external counter write overrides the update above
        if (wr) begin
            if (a == `TMRB_OFS_CTRL) begin
                s_d.enable = bus.wdata[`TMRB_BIT_ENABLE];
                s_d.mode = tmrb_pkg::tmrb_mode_t'(bus.wdata[6:4]);
            end else if (a == `TMRB_OFS_EVCTRL) begin
                s_d.edgeSel = bus.wdata[`TMRB_BIT_EDGE];
                s_d.captEn = bus.wdata[`TMRB_BIT_CAPTEI];
            end else if (a == `TMRB_OFS_INTERRUPT_CONTROL) begin
                s_d.intEn = bus.wdata[`TMRB_BIT_CAPTURE_FLAG];
            end else if (a == `TMRB_OFS_DEBUG_CONTROL) begin
                s_d.dbgCont = bus.wdata[`TMRB_BIT_DBGCONT];
            end else if (a == `TMRB_OFS_STAGING) begin
                s_d.staging = bus.wdata;
            end else if (a == `TMRB_OFS_COUNTER_LOW_BYTE) begin
                s_d.staging = bus.wdata;
            end else if (a == `TMRB_OFS_COUNTER_HIGH_BYTE) begin
                s_d.count = {bus.wdata, s_q.staging};
            end else if (a == `TMRB_OFS_CMPL) begin
                if (s_q.mode == tmrb_pkg::TMRB_PWM8) begin
                    s_d.capture_compare_value[7:0] = bus.wdata;
                end else begin
                    s_d.staging = bus.wdata;
                end
            end else if (a == `TMRB_OFS_CMPH) begin
                if (s_q.mode == tmrb_pkg::TMRB_PWM8) begin
                    s_d.capture_compare_value[15:8] = bus.wdata;
                end else begin
                    s_d.capture_compare_value = {bus.wdata, s_q.staging};
                end
            end
        end

        // reads: low byte read latches high byte into staging, except the compare low byte in 8-bit pwm
        if (rd) begin
            if (a == `TMRB_OFS_CTRL) begin
                s_d.rdata = {1'b0, s_q.mode, 3'h0, s_q.enable};
            end else if (a == `TMRB_OFS_EVCTRL) begin
                s_d.rdata = {3'h0, s_q.edgeSel, 3'h0, s_q.captEn};
            end else if (a == `TMRB_OFS_INTERRUPT_CONTROL) begin
                s_d.rdata = {7'h00, s_q.intEn};
            end else if (a == `TMRB_OFS_INTERRUPT_FLAGS) begin
                s_d.rdata = {7'h00, s_q.flag};
            end else if (a == `TMRB_OFS_RUNSTATE) begin
                s_d.rdata = {7'h00, s_q.running};
            end else if (a == `TMRB_OFS_DEBUG_CONTROL) begin
                s_d.rdata = {7'h00, s_q.dbgCont};
            end else if (a == `TMRB_OFS_STAGING) begin
                s_d.rdata = s_q.staging;
            end else if (a == `TMRB_OFS_COUNTER_LOW_BYTE) begin
                s_d.rdata = s_q.count[7:0];
                if (!wr) begin
                    s_d.staging = s_q.count[15:8];
                end
            end else if (a == `TMRB_OFS_COUNTER_HIGH_BYTE) begin
                s_d.rdata = s_q.staging;
            end else if (a == `TMRB_OFS_CMPL) begin
                s_d.rdata = s_q.capture_compare_value[7:0];
                if (!wr && s_q.mode != tmrb_pkg::TMRB_PWM8) begin
                    s_d.staging = s_q.capture_compare_value[15:8];
                end
            end else if (a == `TMRB_OFS_CMPH) begin
                s_d.rdata = (s_q.mode == tmrb_pkg::TMRB_PWM8) ? s_q.capture_compare_value[15:8] : s_q.staging;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign irq = s_q.flag & s_q.intEn;

    // ==========================================================
    // checks
    property p_top_flag;
        @(posedge mclk) disable iff (!rst_n)
        (topHit && !(wr && a == `TMRB_OFS_COUNTER_HIGH_BYTE)) |=> s_q.flag;
    endproperty
    a_top_flag: assert property (p_top_flag) else $error("flag not set at top");

    property p_capture_value;
        @(posedge mclk) disable iff (!rst_n)
        (act.capture && active && !(wr && (a == `TMRB_OFS_CMPH || a == `TMRB_OFS_CMPL)))
            |=> s_q.capture_compare_value == $past(s_q.count);
    endproperty
    a_capture_value: assert property (p_capture_value) else $error("capture value wrong");

    property p_freq_clear;
        @(posedge mclk) disable iff (!rst_n)
        (active && s_q.mode == tmrb_pkg::TMRB_FREQ && actEdge && !(wr && a == `TMRB_OFS_COUNTER_HIGH_BYTE))
            |=> s_q.count == 16'h0000 && s_q.flag;
    endproperty
    a_freq_clear: assert property (p_freq_clear) else $error("frequency edge not handled");

    property p_pw_capture;
        @(posedge mclk) disable iff (!rst_n)
        (active && s_q.mode == tmrb_pkg::TMRB_PW && othEdge) |=> s_q.flag;
    endproperty
    a_pw_capture: assert property (p_pw_capture) else $error("pulse width flag missing");

    property p_frqpw_stop;
        @(posedge mclk) disable iff (!rst_n)
        (active && s_q.mode == tmrb_pkg::TMRB_FRQPW && actEdge && s_q.secondPhase && !wr)
            |=> !s_q.running && s_q.flag;
    endproperty
    a_frqpw_stop: assert property (p_frqpw_stop) else $error("combined mode did not stop");

    property p_flag_clear;
        @(posedge mclk) disable iff (!rst_n)
        (wr && a == `TMRB_OFS_INTERRUPT_FLAGS && bus.wdata[0] && !act.setFlag && !topHit) |=> !s_q.flag;
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

    property p_halt;
        @(posedge mclk) disable iff (!rst_n)
        (debugBreak && !s_q.dbgCont && !wr) |=> s_q.count == $past(s_q.count);
    endproperty
    a_halt: assert property (p_halt) else $error("counter moved in debug halt");

    property p_cnt_write;
        @(posedge mclk) disable iff (!rst_n)
        (wr && a == `TMRB_OFS_COUNTER_HIGH_BYTE) |=> s_q.count == {$past(bus.wdata), $past(s_q.staging)};
    endproperty
    a_cnt_write: assert property (p_cnt_write) else $error("counter write lost");

    property p_irq;
        @(posedge mclk) disable iff (!rst_n)
        irq == (s_q.flag && s_q.intEn);
    endproperty
    a_irq: assert property (p_irq) else $error("interrupt level wrong");
endmodule

// [tmrb_cpu_model.sv]
// processor-side model: byte reads and writes on the timer register port
// assumes one access per call, signals change just after a rising edge
`timescale 1ns/100ps
module tmrb_cpu_model (
    input wire logic mclk,
    output tmrb_pkg::tmrb_bus_t bus,
    input wire logic [7:0] rdata
);
    initial bus = '0;
    // ======================================================
    // bus cycles
    // released lines carry inverted values so stale data is never mistaken
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wdata: d};
        @(posedge mclk);
        bus <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: ~d};
        #1;
    endtask
    // read data is registered at the taking edge and stands one cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        bus <= '{wrEn: 1'b0, rdEn: 1'b1, addr: a, wdata: 8'h00};
        @(posedge mclk);
        bus <= '{wrEn: 1'b0, rdEn: 1'b0, addr: ~a, wdata: 8'hff};
        #1;
        d = rdata;
    endtask
endmodule

// [test_tmrb_regs.sv]
// self-checking bench of the timer register block
// assumes the processor model drives the register port
`timescale 1ns/100ps
`define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin nErrors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp); end end
module test_tmrb_regs;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic debugBreak = 1'b0;
    logic evIn = 1'b0;
    logic irq;
    logic [7:0] rdata;
    tmrb_pkg::tmrb_bus_t bus;
    int nErrors = 0;
    int nTests = 0;
    int cycles = 0;
    typedef struct packed {logic rd; logic [3:0] a; logic [7:0] d;} tmrb_row_t;
    tmrb_row_t rows [24] = '{
        '{1, 4'h7, 8'h00}, '{1, 4'h8, 8'h00}, '{1, 4'h9, 8'h00}, '{1, 4'ha, 8'h00},
        '{1, 4'hc, 8'h00}, '{0, 4'h8, 8'h01}, '{1, 4'h8, 8'h01}, '{0, 4'h8, 8'h00},
        '{0, 4'h9, 8'h5a}, '{1, 4'h9, 8'h5a}, '{0, 4'h7, 8'h01}, '{1, 4'h7, 8'h00},
        '{1, 4'hf, 8'h00}, '{0, 4'hf, 8'hff}, '{1, 4'hf, 8'h00}, '{0, 4'ha, 8'h34},
        '{1, 4'h9, 8'h34}, '{0, 4'hb, 8'h12}, '{1, 4'ha, 8'h34}, '{1, 4'hb, 8'h12},
        '{0, 4'hc, 8'h78}, '{0, 4'hd, 8'h56}, '{1, 4'hc, 8'h78}, '{1, 4'hd, 8'h56}};

    always #2.5 mclk = ~mclk;

    tmrb_cpu_model cpu (.mclk(mclk), .bus(bus), .rdata(rdata));
    tmrb_regs #(.CNT_W(16)) dut_u (.mclk(mclk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
        .debugBreak(debugBreak), .evIn(evIn), .irq(irq));

    // ======================================================
    // helpers
    task automatic closeOut();
        $display("comparisons %0d mismatches %0d", nTests, nErrors);
        if (nErrors == 0 && nTests > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] got;
        cpu.rd(a, got);
        `CHK(got, e)
    endtask
    task automatic ev(input logic v);
        @(posedge mclk);
        evIn <= v;
        repeat (3) @(posedge mclk);
        #1;
    endtask
    task automatic waitIrq(input int lim);
        for (int i = 0; i < lim && irq !== 1'b1; i++) @(posedge mclk);
        #1;
    endtask
    // 16-bit write: low byte first, high byte commits
    task automatic wr16(input logic [3:0] a, input logic [15:0] v);
        cpu.wr(a, v[7:0]);
        cpu.wr(a + 4'h1, v[15:8]);
    endtask

    // hang guard: whole run is a few hundred cycles
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 20000) begin
            nErrors++;
            closeOut();
        end
    end

    // ======================================================
    // sequence
    initial begin
        repeat (8) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 24; i++) begin
            if (rows[i].rd) begin
                chk(rows[i].a, rows[i].d);
            end else begin
                cpu.wr(rows[i].a, rows[i].d);
            end
        end
        $display("test registers done");
        // periodic: compare value wraps the count to zero
        wr16(4'hc, 16'h0010);
        wr16(4'ha, 16'h0000);
        cpu.wr(4'h5, 8'h01);
        cpu.wr(4'h1, 8'h01);
        chk(4'h7, 8'h01);
        waitIrq(40);
        `CHK(irq, 1'b1)
        cpu.wr(4'h6, 8'h01);
        `CHK(irq, 1'b0)
        cpu.wr(4'h5, 8'h00);
        repeat (40) @(posedge mclk);
        #1;
        `CHK(irq, 1'b0)
        cpu.wr(4'h1, 8'h00);
        chk(4'h7, 8'h00);
        $display("test periodic done");
        // capture on event, first under debug halt
        cpu.wr(4'h6, 8'h01);
        cpu.wr(4'h5, 8'h01);
        cpu.wr(4'h4, 8'h01);
        cpu.wr(4'h1, 8'h21);
        debugBreak <= 1'b1;
        ev(1'b1);
        ev(1'b0);
        chk(4'h6, 8'h00);
        cpu.wr(4'h8, 8'h01);
        wr16(4'ha, 16'h1000);
        ev(1'b1);
        chk(4'h6, 8'h01);
        `CHK(irq, 1'b1)
        chk(4'hc, 8'h00);
        chk(4'hd, 8'h10);
        chk(4'h6, 8'h00);
        `CHK(irq, 1'b0)
        debugBreak <= 1'b0;
        ev(1'b0);
        $display("test capture done");
        // frequency: edge captures and restarts the count
        cpu.wr(4'h1, 8'h31);
        wr16(4'ha, 16'h1000);
        ev(1'b1);
        chk(4'h6, 8'h01);
        chk(4'ha, 8'h00);
        chk(4'hb, 8'h00);
        chk(4'hc, 8'h00);
        chk(4'hd, 8'h10);
        ev(1'b0);
        $display("test frequency done");
        // pulse width: rising restarts, falling captures
        cpu.wr(4'h1, 8'h41);
        cpu.wr(4'h6, 8'h01);
        wr16(4'ha, 16'h2000);
        ev(1'b1);
        chk(4'h6, 8'h00);
        ev(1'b0);
        chk(4'h6, 8'h01);
        chk(4'hc, 8'h00);
        chk(4'hd, 8'h00);
        $display("test pulse width done");
        // combined: restart, capture, then stop and flag
        cpu.wr(4'h1, 8'h51);
        cpu.wr(4'h6, 8'h01);
        ev(1'b1);
        ev(1'b0);
        chk(4'h6, 8'h00);
        ev(1'b1);
        chk(4'h6, 8'h01);
        chk(4'h7, 8'h00);
        ev(1'b0);
        $display("test combined done");
        // 8-bit pwm: compare bytes stand alone, flag at high byte
        cpu.wr(4'h1, 8'h70);
        cpu.wr(4'hc, 8'h40);
        cpu.wr(4'h9, 8'h99);
        cpu.wr(4'hd, 8'h08);
        chk(4'hc, 8'h40);
        wr16(4'ha, 16'h0000);
        cpu.wr(4'h6, 8'h01);
        cpu.wr(4'h1, 8'h71);
        waitIrq(100);
        `CHK(irq, 1'b1)
        $display("test pwm done");
        closeOut();
    end
endmodule
